// ===== hdl/cbb_pkg.sv
// Purpose: shared offsets, reset values and field positions for the bridge header block
// Assumes: byte offsets within a 256-byte configuration space
// Notes:   doubleword index is offset[7:2]
package cbb_pkg;

   // configuration byte offsets
   localparam logic [7:0] HDR_TYPE_OFS   = 8'h0E;
   localparam logic [7:0] SELF_TEST_OFS  = 8'h0F;
   localparam logic [7:0] SOCK_BASE_OFS  = 8'h10;
   localparam logic [7:0] CAP_PTR_OFS    = 8'h14;
   localparam logic [7:0] SEC_STAT_OFS   = 8'h16;
   localparam logic [7:0] UP_BUS_OFS     = 8'h18;
   localparam logic [7:0] DN_BUS_OFS     = 8'h19;
   localparam logic [7:0] SUB_BUS_OFS    = 8'h1A;
   localparam logic [7:0] STD_HDR_LAST   = 8'h7F;
   localparam logic [7:0] EXT_FIRST_OFS  = 8'h80;
   localparam logic [7:0] PM_BLOCK0_OFS  = 8'hA0;
   localparam logic [7:0] PM_BLOCK1_OFS  = 8'hA4;

   // fixed read values and reset values
   localparam logic [7:0]  HDR_TYPE_VAL  = 8'h02;
   localparam logic [7:0]  SELF_TEST_VAL = 8'h00;
   localparam logic [7:0]  CAP_PTR_VAL   = 8'hA0;
   localparam logic [31:0] SOCK_BASE_RST = 32'h00000000;
   localparam logic [31:0] SOCK_BASE_MSK = 32'hFFFFF000;
   localparam logic [15:0] SEC_STAT_RST  = 16'h0200;
   localparam logic [7:0]  BUS_NUM_RST   = 8'h00;

   // socket window layout
   localparam int          SOCK_ALIGN_BITS = 12;
   localparam logic [11:0] SOCK_REG_OFS    = 12'h000;
   localparam logic [11:0] EXCA_REG_OFS    = 12'h800;

   // secondary status field positions
   localparam int PARITY_BIT   = 15;
   localparam int CARD_SERR_BIT = 14;
   localparam int MABORT_BIT   = 13;
   localparam int TABORT_RX_BIT = 12;
   localparam int TABORT_TX_BIT = 11;
   localparam int SPEED_HI_BIT = 10;
   localparam int SPEED_LO_BIT = 9;
   localparam int DPAR_BIT     = 8;
   localparam int B2B_BIT      = 7;
   localparam int UDF_BIT      = 6;
   localparam int DBL_SPD_BIT  = 5;
   localparam logic [1:0]  SELECT_TIMING_VAL = 2'h1;
   localparam logic [15:0] SEC_STAT_W1C_MSK  = 16'hF900;
   localparam logic [15:0] SEC_STAT_FIX_MSK  = 16'h0200;

endpackage

// ===== hdl/cbb_event_if.sv
// Purpose: carries set, clear and state of the sticky status bits
// Assumes: all signals on the configuration clock
// Notes:   owner raises events and clears, keeper holds the flags
`timescale 1ns/1ns
interface cbb_event_if;
   logic [15:0] setVec;
   logic [15:0] clrVec;
   logic [15:0] stat;

   modport owner (output setVec, output clrVec, input stat);
   modport keeper (input setVec, input clrVec, output stat);
endinterface // cbb_event_if

// ===== hdl/cbb_sticky_status.sv
// Purpose: secondary status flags with write-one-to-clear behaviour
// Assumes: set and clear pulses are synchronous to clk
// Notes:   fixed bits are forced every cycle, not only at reset
`timescale 1ns/1ns
module cbb_sticky_status (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // flags
   cbb_event_if.keeper evt
);

   logic [15:0] stat_q;
   logic [15:0] stat_d;
   logic [15:0] kept;

   // set beats clear in the same cycle so no event is lost
   assign kept   = stat_q & ~evt.clrVec;
   assign stat_d = ((kept | evt.setVec) & cbb_pkg::SEC_STAT_W1C_MSK)
                   | cbb_pkg::SEC_STAT_FIX_MSK;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stat_q <= cbb_pkg::SEC_STAT_RST;
      end else begin
         stat_q <= stat_d;
      end
   end

   assign evt.stat = stat_q;

endmodule // cbb_sticky_status

// ===== hdl/cbb_config_header.sv
// Purpose: bridge header registers, window decode and bus-number forwarding decision
// Assumes: configuration, memory and forwarding requests are single-cycle strobes on clk
// Notes:   answers arrive one clock after the strobe, from flip-flops
`timescale 1ns/1ns
module cbb_config_header (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // configuration access
   input  wire logic        cfgValid,
   input  wire logic        cfgWrite,
   input  wire logic [7:0]  cfgAddr,
   input  wire logic [3:0]  cfgByteEn,
   input  wire logic [31:0] cfgWrData,
   output logic      [31:0] cfgRdData,
   output logic             cfgDone,
   // device-specific extension space
   output logic             extValid,
   output logic             extPmSel,
   input  wire logic [31:0] extRdData,
   // downstream events
   input  wire logic        downstream_parity_detected,
   input  wire logic        cardSerrN,
   input  wire logic        downstream_master_abort_received,
   input  wire logic        downstream_target_abort_received,
   input  wire logic        downstream_target_abort_signaled,
   input  wire logic        cardPerrSeen,
   input  wire logic        masterInDataPhase,
   input  wire logic        parityRespEnable,
   // card system error pin
   output logic             cardSerrOut,
   output logic             cardSerrOe,
   // socket memory window
   input  wire logic        memValid,
   input  wire logic [31:0] memAddr,
   output logic             memClaim,
   output logic             sockRegSel,
   output logic             excaRegSel,
   output logic      [10:0] winOffset,
   // configuration forwarding
   input  wire logic        fwdValid,
   input  wire logic [7:0]  fwdBus,
   output logic             fwdType0,
   output logic             fwdType1,
   // bus number values
   output logic      [7:0]  upstreamBus,
   output logic      [7:0]  downstreamBus,
   output logic      [7:0]  subordinateBus
);

   // byte lane select with byte enable
   function automatic logic laneWr(
      input logic       hit,
      input logic [3:0] be,
      input logic [7:0] ofs
   );
      laneWr = hit & be[ofs[1:0]];
   endfunction

   // dword match of an access address against a byte offset
   function automatic logic dwHit(
      input logic [7:0] addr,
      input logic [7:0] ofs
   );
      dwHit = (addr[7:2] == ofs[7:2]);
   endfunction

   // byte of the write data that belongs to a given offset
   function automatic logic [7:0] laneData(
      input logic [31:0] data,
      input logic [7:0]  ofs
   );
      laneData = data[8 * ofs[1:0] +: 8];
   endfunction

   // decode
   wire         isExt;
   wire         wrEn;
   wire         hitSock;
   wire         hitCap;
   wire         hitBus;
   wire         hitHdr;

   assign isExt   = cfgAddr >= cbb_pkg::EXT_FIRST_OFS;
   assign wrEn    = cfgValid & cfgWrite & ~isExt;
   assign hitSock = dwHit(cfgAddr, cbb_pkg::SOCK_BASE_OFS);
   assign hitCap  = dwHit(cfgAddr, cbb_pkg::CAP_PTR_OFS);
   assign hitBus  = dwHit(cfgAddr, cbb_pkg::UP_BUS_OFS);
   assign hitHdr  = dwHit(cfgAddr, cbb_pkg::HDR_TYPE_OFS);

   // extension accesses are handed out unchanged
   assign extValid = cfgValid & isExt;
   assign extPmSel = extValid &
                     (dwHit(cfgAddr, cbb_pkg::PM_BLOCK0_OFS) |
                      dwHit(cfgAddr, cbb_pkg::PM_BLOCK1_OFS));

   // socket base register
   logic [31:0] sockBase_q;
   logic [31:0] sockBase_d;
   wire  [3:0]  sockLaneWr;
   wire  [31:0] sockMerged;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sock
         assign sockLaneWr[gi] = wrEn & hitSock & cfgByteEn[gi];
         assign sockMerged[8*gi +: 8] = sockLaneWr[gi] ? cfgWrData[8*gi +: 8]
                                                       : sockBase_q[8*gi +: 8];
      end
   endgenerate

   // low bits masked so sizing reads back the 4K window
   assign sockBase_d = sockMerged & cbb_pkg::SOCK_BASE_MSK;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sockBase_q <= cbb_pkg::SOCK_BASE_RST;
      end else begin
         sockBase_q <= sockBase_d;
      end
   end

   // bus number registers
   logic [7:0] upBus_q;
   logic [7:0] dnBus_q;
   logic [7:0] subBus_q;
   wire        upWr;
   wire        dnWr;
   wire        subWr;

   assign upWr  = laneWr(wrEn & hitBus, cfgByteEn, cbb_pkg::UP_BUS_OFS);
   assign dnWr  = laneWr(wrEn & hitBus, cfgByteEn, cbb_pkg::DN_BUS_OFS);
   assign subWr = laneWr(wrEn & hitBus, cfgByteEn, cbb_pkg::SUB_BUS_OFS);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         upBus_q  <= cbb_pkg::BUS_NUM_RST;
         dnBus_q  <= cbb_pkg::BUS_NUM_RST;
         subBus_q <= cbb_pkg::BUS_NUM_RST;
      end else begin
         if (upWr) begin
            upBus_q <= laneData(cfgWrData, cbb_pkg::UP_BUS_OFS);
         end
         if (dnWr) begin
            dnBus_q <= laneData(cfgWrData, cbb_pkg::DN_BUS_OFS);
         end
         if (subWr) begin
            subBus_q <= laneData(cfgWrData, cbb_pkg::SUB_BUS_OFS);
         end
      end
   end

   assign upstreamBus    = upBus_q;
   assign downstreamBus  = dnBus_q;
   assign subordinateBus = subBus_q;

   // card system error pin: two-stage synchroniser, never driven
   logic serrMeta_q;
   logic serrSync_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         serrMeta_q <= 1'b0;
         serrSync_q <= 1'b0;
      end else begin
         serrMeta_q <= ~cardSerrN;
         serrSync_q <= serrMeta_q;
      end
   end

   assign cardSerrOut = 1'b0;
   assign cardSerrOe  = 1'b0;

   // secondary status events
   cbb_event_if evtBus ();

   wire card_system_error_seen;
   wire downstream_master_data_parity;
   wire [15:0] clrStat;
   logic [15:0] setStat;
   wire        statLoWr;
   wire        statHiWr;

   assign card_system_error_seen = serrSync_q;
   // bit 8 needs all three conditions at once
   assign downstream_master_data_parity = cardPerrSeen & masterInDataPhase
                                          & parityRespEnable;

   always_comb begin
      setStat = 16'h0000;
      setStat[cbb_pkg::PARITY_BIT]    = downstream_parity_detected;
      setStat[cbb_pkg::CARD_SERR_BIT] = card_system_error_seen;
      setStat[cbb_pkg::MABORT_BIT]    = downstream_master_abort_received;
      setStat[cbb_pkg::TABORT_RX_BIT] = downstream_target_abort_received;
      setStat[cbb_pkg::TABORT_TX_BIT] = downstream_target_abort_signaled;
      setStat[cbb_pkg::DPAR_BIT]      = downstream_master_data_parity;
   end

   // write-one-to-clear per byte lane, zero leaves the bit
   assign statLoWr = laneWr(wrEn & hitCap, cfgByteEn, cbb_pkg::SEC_STAT_OFS);
   assign statHiWr = laneWr(wrEn & hitCap, cfgByteEn, cbb_pkg::SEC_STAT_OFS + 8'h01);
   assign clrStat  = {statHiWr ? cfgWrData[31:24] : 8'h00,
                      statLoWr ? cfgWrData[23:16] : 8'h00};

   assign evtBus.setVec = setStat;
   assign evtBus.clrVec = clrStat;

   cbb_sticky_status u_status (
      .clk     (clk),
      .sys_rst (sys_rst),
      .evt     (evtBus.keeper)
   );

   wire [15:0] secStatus;
   wire [1:0]  downstream_select_timing;
   wire        downstream_back_to_back_capable;
   wire        downstream_user_feature_flag;
   wire        downstream_double_speed_capable;

   assign secStatus                       = evtBus.stat;
   assign downstream_select_timing        = secStatus[cbb_pkg::SPEED_HI_BIT:cbb_pkg::SPEED_LO_BIT];
   assign downstream_back_to_back_capable = secStatus[cbb_pkg::B2B_BIT];
   assign downstream_user_feature_flag    = secStatus[cbb_pkg::UDF_BIT];
   assign downstream_double_speed_capable = secStatus[cbb_pkg::DBL_SPD_BIT];

   // read data assembly, fixed fields from constants
   wire [31:0] hdrWord;
   wire [31:0] capWord;
   wire [31:0] busWord;
   wire [31:0] stdWord;
   wire [31:0] rdNext;

   assign hdrWord = {cbb_pkg::SELF_TEST_VAL, cbb_pkg::HDR_TYPE_VAL, 16'h0000};
   assign capWord = {secStatus[15:11],
                     downstream_select_timing,
                     secStatus[cbb_pkg::DPAR_BIT],
                     downstream_back_to_back_capable,
                     downstream_user_feature_flag,
                     downstream_double_speed_capable,
                     5'h00,
                     8'h00,
                     cbb_pkg::CAP_PTR_VAL};
   assign busWord = {8'h00, subBus_q, dnBus_q, upBus_q};

   // unimplemented standard offsets read zero
   assign stdWord = hitHdr  ? hdrWord :
                    hitSock ? sockBase_q :
                    hitCap  ? capWord :
                    hitBus  ? busWord : 32'h00000000;
   assign rdNext  = isExt ? extRdData : stdWord;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfgRdData <= 32'h00000000;
         cfgDone   <= 1'b0;
      end else begin
         cfgDone <= cfgValid;
         if (cfgValid & ~cfgWrite) begin
            cfgRdData <= rdNext;
         end
      end
   end

   // socket window decode; zero base keeps the window closed
   wire        baseSet;
   wire        winHit;
   wire [11:0] winOfs;

   assign baseSet = |sockBase_q[31:cbb_pkg::SOCK_ALIGN_BITS];
   assign winHit  = memValid & baseSet &
                    (memAddr[31:cbb_pkg::SOCK_ALIGN_BITS] ==
                     sockBase_q[31:cbb_pkg::SOCK_ALIGN_BITS]);
   assign winOfs  = memAddr[cbb_pkg::SOCK_ALIGN_BITS-1:0];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         memClaim   <= 1'b0;
         sockRegSel <= 1'b0;
         excaRegSel <= 1'b0;
         winOffset  <= 11'h000;
      end else begin
         memClaim   <= winHit;
         sockRegSel <= winHit & (winOfs < cbb_pkg::EXCA_REG_OFS);
         excaRegSel <= winHit & (winOfs >= cbb_pkg::EXCA_REG_OFS);
         winOffset  <= winOfs[10:0];
      end
   end

   // forwarding decision on the downstream range
   wire toDown;
   wire toBelow;

   assign toDown  = fwdValid & (fwdBus == dnBus_q);
   assign toBelow = fwdValid & (fwdBus > dnBus_q) & (fwdBus <= subBus_q);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fwdType0 <= 1'b0;
         fwdType1 <= 1'b0;
      end else begin
         fwdType0 <= toDown;
         fwdType1 <= toBelow;
      end
   end

endmodule // cbb_config_header

// ===== verif/cbb_config_header_checker.sv
// Purpose: port-level assertions for the bridge header block
// Assumes: single clock, synchronous active-high reset
// Notes:   register contents are judged through read answers
`timescale 1ns/1ns
module cbb_config_header_checker (
   // clock and reset
   input wire logic        clk,
   input wire logic        sys_rst,
   // configuration access
   input wire logic        cfgValid,
   input wire logic        cfgWrite,
   input wire logic [7:0]  cfgAddr,
   input wire logic [3:0]  cfgByteEn,
   input wire logic [31:0] cfgRdData,
   input wire logic        extValid,
   input wire logic        extPmSel,
   // card pin
   input wire logic        cardSerrOut,
   input wire logic        cardSerrOe,
   // memory window and forwarding
   input wire logic        memValid,
   input wire logic [31:0] memAddr,
   input wire logic        memClaim,
   input wire logic        sockRegSel,
   input wire logic        excaRegSel,
   input wire logic        fwdValid,
   input wire logic [7:0]  fwdBus,
   input wire logic        fwdType0,
   input wire logic        fwdType1,
   input wire logic [7:0]  upstreamBus,
   input wire logic [7:0]  downstreamBus,
   input wire logic [7:0]  subordinateBus
);
   wire        rdFull   = cfgValid && !cfgWrite && cfgByteEn == 4'hF;
   wire [5:0]  rdDw     = cfgAddr[7:2];
   wire [19:0] memUpper = memAddr[31:12];
   wire        memHalf  = memAddr[11];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_serr_never_driven: assert property (!cardSerrOe && !cardSerrOut)
      else $error("card error pin driven");
   a_ext_route: assert property (extValid == (cfgValid && cfgAddr >= 8'h80))
      else $error("extension routing wrong");
   a_pm_block_sel: assert property (extPmSel == (extValid && (rdDw == 6'h28 || rdDw == 6'h29)))
      else $error("power block select wrong");
   a_hdr_selftest_read: assert property (rdFull && rdDw == 6'h03 |=> cfgRdData[31:16] == 16'h0002)
      else $error("header or self-test byte wrong");
   a_base_low_zero: assert property (rdFull && rdDw == 6'h04 |=> cfgRdData[11:0] == 12'h000)
      else $error("base low bits not zero");
   a_status_fixed: assert property (rdFull && rdDw == 6'h05 |=> (cfgRdData & 32'h06FFFFFF) == 32'h020000A0)
      else $error("fixed status or pointer bits wrong");
   a_bus_readback: assert property (rdFull && rdDw == 6'h06 |=>
      cfgRdData == {8'h00, $past(subordinateBus), $past(downstreamBus), $past(upstreamBus)})
      else $error("bus number readback wrong");
   a_claim_needs_hit: assert property (memClaim |-> $past(memValid) && $past(memUpper) != 20'h00000)
      else $error("claim without request");
   a_window_split: assert property (memClaim |-> sockRegSel == !$past(memHalf) && excaRegSel == $past(memHalf))
      else $error("window half select wrong");
   a_fwd_type0: assert property (fwdValid && fwdBus == downstreamBus |=> fwdType0 && !fwdType1)
      else $error("type-0 forward missing");
   a_fwd_type1: assert property (fwdValid && fwdBus > downstreamBus && fwdBus <= subordinateBus
      |=> fwdType1 && !fwdType0)
      else $error("type-1 forward missing");
   a_fwd_idle: assert property (!fwdValid |=> !fwdType0 && !fwdType1)
      else $error("forward without request");

   c_claim: cover property (memClaim && excaRegSel);
   c_type0: cover property (fwdType0);
   c_type1: cover property (fwdType1);
   c_pm_sel: cover property (extPmSel);
endmodule // cbb_config_header_checker

bind cbb_config_header cbb_config_header_checker cbb_config_header_checker_i (
   .clk, .sys_rst, .cfgValid, .cfgWrite, .cfgAddr, .cfgByteEn, .cfgRdData, .extValid, .extPmSel, .cardSerrOut,
   .cardSerrOe, .memValid, .memAddr, .memClaim, .sockRegSel, .excaRegSel, .fwdValid, .fwdBus, .fwdType0,
   .fwdType1, .upstreamBus, .downstreamBus, .subordinateBus);

// ===== verif/cbb_host_model.sv
// Purpose: host side issuing single configuration cycles
// Assumes: request is a one-cycle pulse, answer stands the next cycle
// Notes:   idle lines carry the inverse of the last request
`timescale 1ns/1ns
module cbb_host_model (
   // clock
   input  wire logic        clk,
   // requests
   output logic             cfgValid,
   output logic             cfgWrite,
   output logic      [7:0]  cfgAddr,
   output logic      [3:0]  cfgByteEn,
   output logic      [31:0] cfgWrData,
   // answers
   input  wire logic [31:0] cfgRdData,
   input  wire logic        cfgDone
);
   initial begin
      {cfgValid, cfgWrite, cfgAddr, cfgByteEn, cfgWrData} = 46'h0;
   end

   task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                       output logic [31:0] rd, output logic ok);
      @(posedge clk);
      #1;
      {cfgValid, cfgWrite, cfgAddr, cfgWrData} = {1'b1, w, a, d};
      cfgByteEn = be; // clears reach only the enabled lanes
      @(posedge clk);
      #1;
      // stale values must not look like a live request
      {cfgValid, cfgWrite, cfgAddr, cfgByteEn, cfgWrData} = {1'b0, ~w, ~a, ~be, ~d};
      ok = cfgDone;
      rd = cfgRdData;
   endtask
endmodule // cbb_host_model

// ===== verif/test_cbb_config_header.sv
// Purpose: self-checking bench for the bridge header block
// Assumes: host model makes every configuration cycle
// Notes:   event inputs pulse one cycle, status is read a few cycles later
`timescale 1ns/1ns
module test_cbb_config_header;
   typedef struct packed {
      logic        w;
      logic [7:0]  a;
      logic [3:0]  be;
      logic [31:0] d;
      logic [31:0] e;
   } cbb_tb_row_t;
   localparam logic [31:0] EXT_PAT = 32'h5AC33CA5;
   logic        clk, sys_rst, cfgValid, cfgWrite, cfgDone, extValid, extPmSel, cardSerrN, cardSerrOut, cardSerrOe;
   logic        downstream_parity_detected, downstream_master_abort_received, downstream_target_abort_received;
   logic        downstream_target_abort_signaled, cardPerrSeen, masterInDataPhase, parityRespEnable;
   logic        memValid, memClaim, sockRegSel, excaRegSel, fwdValid, fwdType0, fwdType1;
   logic [3:0]  cfgByteEn;
   logic [7:0]  cfgAddr, fwdBus, upstreamBus, downstreamBus, subordinateBus;
   logic [10:0] winOffset;
   logic [31:0] cfgWrData, cfgRdData, extRdData, memAddr;
   logic [15:0] evMask [7] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0100, 16'h0000};
   int          error_cnt = 0;
   int          checks_done = 0;
   int          cycles = 0;
   cbb_tb_row_t rows [17] = '{
      '{1'b0, 8'h0C, 4'hF, 32'h0, 32'h00020000}, '{1'b0, 8'h10, 4'hF, 32'h0, 32'h00000000},
      '{1'b0, 8'h14, 4'hF, 32'h0, 32'h020000A0}, '{1'b0, 8'h18, 4'hF, 32'h0, 32'h00000000},
      '{1'b1, 8'h0C, 4'hF, 32'hFFFFFFFF, 32'h0}, '{1'b0, 8'h0C, 4'hF, 32'h0, 32'h00020000},
      '{1'b1, 8'h10, 4'hF, 32'hFFFFFFFF, 32'h0}, '{1'b0, 8'h10, 4'hF, 32'h0, 32'hFFFFF000},
      '{1'b1, 8'h14, 4'hF, 32'hFFFFFFFF, 32'h0}, '{1'b0, 8'h14, 4'hF, 32'h0, 32'h020000A0},
      '{1'b1, 8'h18, 4'hF, 32'hAA050301, 32'h0}, '{1'b0, 8'h18, 4'hF, 32'h0, 32'h00050301},
      '{1'b1, 8'h18, 4'h2, 32'h00007700, 32'h0}, '{1'b0, 8'h18, 4'hF, 32'h0, 32'h00057701},
      '{1'b0, 8'h20, 4'hF, 32'h0, 32'h00000000}, '{1'b0, 8'hA0, 4'hF, 32'h0, EXT_PAT},
      '{1'b1, 8'h18, 4'h2, 32'h00000300, 32'h0}};

   cbb_config_header cbb_config_header_i (.clk, .sys_rst, .cfgValid, .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWrData,
      .cfgRdData, .cfgDone, .extValid, .extPmSel, .extRdData, .downstream_parity_detected, .cardSerrN,
      .downstream_master_abort_received, .downstream_target_abort_received, .downstream_target_abort_signaled,
      .cardPerrSeen, .masterInDataPhase, .parityRespEnable, .cardSerrOut, .cardSerrOe, .memValid, .memAddr,
      .memClaim, .sockRegSel, .excaRegSel, .winOffset, .fwdValid, .fwdBus, .fwdType0, .fwdType1, .upstreamBus,
      .downstreamBus, .subordinateBus);
   cbb_host_model cbb_host_model_i (.clk, .cfgValid, .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWrData, .cfgRdData,
      .cfgDone);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         $display("MISMATCH at %0t: run did not finish", $time);
         end_sim();
      end
   end

   task automatic chk(input string m, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                       input logic [31:0] e);
      logic [31:0] rd;
      logic        ok;
      cbb_host_model_i.xfer(w, a, be, d, rd, ok);
      chk("cfg done", {31'h0, ok}, 32'h1);
      if (!w) chk($sformatf("read %h", a), rd, e);
   endtask

   task automatic idle_evt();
      {downstream_parity_detected, downstream_master_abort_received, downstream_target_abort_received,
       downstream_target_abort_signaled, cardPerrSeen, masterInDataPhase, parityRespEnable} = 7'h00;
      cardSerrN = 1'b1;
   endtask

   // card error pin needs two sync stages, so settle before reading
   task automatic fire(input int k);
      @(posedge clk);
      #1;
      case (k)
         0: downstream_parity_detected = 1'b1;
         1: cardSerrN = 1'b0;
         2: downstream_master_abort_received = 1'b1;
         3: downstream_target_abort_received = 1'b1;
         4: downstream_target_abort_signaled = 1'b1;
         5: {cardPerrSeen, masterInDataPhase, parityRespEnable} = 3'h7;
         default: {cardPerrSeen, masterInDataPhase, parityRespEnable} = 3'h6;
      endcase
      @(posedge clk);
      #1;
      idle_evt();
      repeat (4) @(posedge clk);
   endtask

   task automatic mem(input logic [31:0] a, input logic [2:0] exp);
      @(posedge clk);
      #1;
      {memValid, memAddr} = {1'b1, a};
      @(posedge clk);
      #1;
      {memValid, memAddr} = {1'b0, ~a};
      chk($sformatf("claim %h", a), {29'h0, memClaim, sockRegSel, excaRegSel}, {29'h0, exp});
      if (exp[2]) chk($sformatf("offset %h", a), {21'h0, winOffset}, {21'h0, a[10:0]});
   endtask

   task automatic fwd(input logic [7:0] b, input logic [1:0] exp);
      @(posedge clk);
      #1;
      {fwdValid, fwdBus} = {1'b1, b};
      @(posedge clk);
      #1;
      {fwdValid, fwdBus} = {1'b0, ~b};
      chk($sformatf("forward %h", b), {30'h0, fwdType0, fwdType1}, {30'h0, exp});
   endtask

   initial begin
      sys_rst = 1'b1;
      extRdData = EXT_PAT;
      {memValid, fwdValid, memAddr, fwdBus} = 42'h0;
      idle_evt();
      repeat (4) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      foreach (rows[i]) xfer(rows[i].w, rows[i].a, rows[i].be, rows[i].d, rows[i].e);
      $display("test register table done");
      for (int k = 0; k < 7; k++) begin
         fire(k);
         xfer(1'b0, 8'h14, 4'hF, 32'h0, {16'h0200 | evMask[k], 16'h00A0});
         xfer(1'b1, 8'h14, 4'hC, 32'h0, 32'h0);
         xfer(1'b0, 8'h14, 4'hF, 32'h0, {16'h0200 | evMask[k], 16'h00A0});
         xfer(1'b1, 8'h14, 4'hC, 32'hF9000000, 32'h0);
         xfer(1'b0, 8'h14, 4'hF, 32'h0, 32'h020000A0);
      end
      // event and clearing write meet at one edge: the event must survive
      fork
         xfer(1'b1, 8'h14, 4'hC, 32'hF9000000, 32'h0);
         fire(2);
      join
      xfer(1'b0, 8'h14, 4'hF, 32'h0, 32'h220000A0);
      $display("test status events done");
      mem(32'hFFFFF010, 3'h6);
      mem(32'hFFFFF800, 3'h5);
      mem(32'hFFFFE010, 3'h0);
      xfer(1'b1, 8'h10, 4'hF, 32'h0, 32'h0);
      mem(32'h00000010, 3'h0);
      $display("test memory window done");
      for (int b = 2; b < 7; b++) fwd(b[7:0], b == 3 ? 2'h2 : (b > 3 && b < 6) ? 2'h1 : 2'h0);
      $display("test forwarding done");
      xfer(1'b1, 8'h10, 4'hF, 32'hFFFFFFFF, 32'h0);
      fire(0);
      #1;
      sys_rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      xfer(1'b0, 8'h18, 4'hF, 32'h0, 32'h00000000);
      xfer(1'b0, 8'h14, 4'hF, 32'h0, 32'h020000A0);
      xfer(1'b0, 8'h10, 4'hF, 32'h0, 32'h00000000);
      $display("test second reset done");
      end_sim();
   end
endmodule // test_cbb_config_header
